// ---- design/mcd_pkg.sv ----
// Shared constants and types of the 8-bit controller core decoder.
// Assumes one clock and a synchronous, active-high reset.
package mcd_pkg;

	// Values after reset
	localparam logic [11:0] PC_RESET   = 12'h000;
	localparam logic [7:0]  PORT_RESET = 8'hFF;
	localparam logic [2:0]  SP_RESET   = 3'h0;

	// Interrupt entry points, low byte of page 0
	localparam logic [7:0]  VEC_EXT    = 8'h03;
	localparam logic [7:0]  VEC_TIMER  = 8'h07;

	// Data RAM size and the first stack byte; each level takes two bytes
	localparam int          RAM_WORDS  = 64;
	localparam logic [5:0]  STACK_BASE = 6'h08;

	// Timer mode advances once per this many machine cycles, plus one
	localparam logic [4:0]  PRESCALE_LAST = 5'h1F;

	// Machine cycle within an instruction
	typedef enum logic [1:0] {ST_FETCH, ST_EXEC2, ST_INTR} mcd_state_t;

	// Timer/counter source
	typedef enum logic [1:0] {TM_STOP, TM_TIMER, TM_COUNT} mcd_tmode_t;

	// Expander transfer: op 0 read, 1 write, 2 or, 3 and
	typedef struct packed {
		logic       strobe;
		logic [1:0] op;
		logic [1:0] port;
		logic [3:0] data;
	} mcd_exp_t;

	// All core state, registered as one word
	typedef struct packed {
		mcd_state_t  state;
		logic [7:0]  op;
		logic        imm;
		logic [11:0] pc;
		logic [11:0] addr;
		logic        pext;
		logic [7:0]  acc;
		logic        cy, ac, f0, f1, mbf;
		logic [2:0]  sp;
		logic        irq_en, tirq_en, tpend, tf, insvc, t1_prev;
		mcd_tmode_t  tmode;
		logic [4:0]  presc;
		logic [7:0]  timer, p1, p2, bus, xaddr;
		logic        bus_oe_n, rd_n, wr_n;
		mcd_exp_t    exp;
	} mcd_regs_t;

	localparam mcd_regs_t REGS_RESET = '{state: ST_FETCH, tmode: TM_STOP, pc: PC_RESET,
		addr: PC_RESET, sp: SP_RESET, p1: PORT_RESET, p2: PORT_RESET, bus_oe_n: 1'b1,
		rd_n: 1'b1, wr_n: 1'b1, default: '0};

endpackage

// ---- design/mcd_core.sv ----
// Instruction decode and execute core: one machine cycle per clock.
// Assumes all inputs synchronous to clk_sys and external memory that
// answers prog_addr within the same cycle.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - external access input forces external program fetch
// - add register, indirect or immediate, sets carries
// - add with carry, same three forms
// - and, or, xor in register/indirect/immediate forms
// - accumulator increment, decrement, clear, complement, decimal adjust
// - nibble swap and rotates, carry variants use carry
// - port read, write, and/or immediate, two cycles
// - bus strobed read, write, and/or immediate
// - expander read, write, and, or via low nibble
// - register and indirect increment, register decrement, carry untouched
// - long jump from opcode bits and bank flag
// - indirect jump through accumulator within page
// - decrement register, branch while nonzero
// - branch on carry set or clear
// - branch on accumulator zero or nonzero
// - branch on test inputs, user flags, timer, interrupt
// - call pushes pc and upper status, jumps
// - exchange accumulator with register, RAM, or nibble
// - external data read and write through pointer
// - table read in current page or page three
// - timer interrupt enable and disable opcodes
// - external interrupt disabled at reset, level gated
module mcd_core #(
	parameter int ROM_AW = 10
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// Program memory
	input  wire logic              external_fetch_select,
	input  wire logic              prog_load_en,
	input  wire logic [ROM_AW-1:0] prog_load_addr,
	input  wire logic [7:0]        prog_load_data,
	input  wire logic [7:0]        prog_data_in,
	output logic [11:0]            prog_addr,
	output logic                   prog_ext_en,
	// Ports 1 and 2
	input  wire logic [7:0]        port1_in,
	input  wire logic [7:0]        port2_in,
	output logic [7:0]             port1_out,
	output logic [7:0]             port2_out,
	// Data bus and external data memory
	input  wire logic [7:0]        bus_in,
	output logic [7:0]             bus_out,
	output logic                   bus_oe_n,
	output logic                   bus_rd_n,
	output logic                   bus_wr_n,
	output logic [7:0]             xdata_addr,
	// Expander
	input  wire logic [3:0]        exp_in,
	output var mcd_pkg::mcd_exp_t  exp_out,
	// Test and interrupt inputs
	input  wire logic              test_input_a,
	input  wire logic              test_input_b,
	input  wire logic              ext_irq_n,
	// Visible state
	output logic [7:0]             acc_out,
	output logic [7:0]             status_word
);

	if (ROM_AW < 8 || ROM_AW > 11) begin : g_chk
		$error("ROM_AW must lie between 8 and 11");
	end

	mcd_pkg::mcd_regs_t r_reg;                   // All core state
	mcd_pkg::mcd_regs_t r_next;                  // Its next value
	logic [7:0]  rom [2**ROM_AW];                // Internal program store
	logic [7:0]  ram [mcd_pkg::RAM_WORDS];       // Registers, stack, data
	logic        ram_we;                         // RAM write this cycle
	logic [5:0]  ram_wa;                         // RAM write address
	logic [7:0]  ram_wd;                         // RAM write data
	logic [11:0] pc1;                            // Program counter plus one
	logic [7:0]  fetch_byte;                     // Byte read at r_reg.addr
	logic [7:0]  cur;                            // Opcode being decoded
	logic [7:0]  ptr;                            // Pointer register R0/R1
	logic [5:0]  mem_a;                          // Register or indirect address
	logic [7:0]  mem_q;                          // Data at mem_a
	logic [5:0]  stk_a;                          // Low byte of stack level
	logic [9:0]  alu_r;                          // Carry, aux carry, result
	logic [8:0]  da_lo;                          // Decimal adjust, low step
	logic [8:0]  da_hi;                          // Decimal adjust, high step
	logic [1:0]  cnd;                            // Branch valid, condition
	logic        tick;                           // Timer/counter advances
	logic        take_ext;                       // Enter external interrupt
	logic        take_tmr;                       // Enter timer interrupt

	// Add family returns carry and aux carry; logic family returns them cleared
	function automatic logic [9:0] alu(input logic [3:0] kind, input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		case (kind)
			4'h4: alu = {2'b00, a | b};
			4'h5: alu = {2'b00, a & b};
			4'hD: alu = {2'b00, a ^ b};
			default: alu = {s[8], n[4], s[7:0]};
		endcase
	endfunction

	// Decode and execute one machine cycle
	always_comb begin
		r_next = r_reg;
		pc1 = r_reg.pc + 12'h001;
		fetch_byte = r_reg.pext ? prog_data_in : rom[r_reg.addr[ROM_AW-1:0]];
		cur = (r_reg.state == mcd_pkg::ST_FETCH) ? fetch_byte : r_reg.op;
		ptr = ram[{5'h00, cur[0]}];
		mem_a = cur[3] ? {3'h0, cur[2:0]} : ptr[5:0];
		mem_q = ram[mem_a];
		stk_a = mcd_pkg::STACK_BASE + {2'b00, r_reg.sp, 1'b0};
		ram_we = 1'b0;
		ram_wa = mem_a;
		ram_wd = r_reg.acc;
		alu_r = alu(cur[7:4], r_reg.acc,
			(r_reg.state == mcd_pkg::ST_FETCH) ? mem_q : fetch_byte, cur[4] & r_reg.cy);
		da_lo = (r_reg.acc[3:0] > 4'h9 || r_reg.ac) ? {1'b0, r_reg.acc} + 9'h006
			: {1'b0, r_reg.acc};
		da_hi = (da_lo[7:4] > 4'h9 || da_lo[8] || r_reg.cy) ? da_lo + 9'h060 : da_lo;
		// branch conditions by opcode high nibble
		case (cur[7:4])
			4'h1: cnd = {1'b1, r_reg.tf};
			4'h2: cnd = {1'b1, ~test_input_a};
			4'h3: cnd = {1'b1, test_input_a};
			4'h4: cnd = {1'b1, ~test_input_b};
			4'h5: cnd = {1'b1, test_input_b};
			4'h7: cnd = {1'b1, r_reg.f1};
			4'h8: cnd = {1'b1, ~ext_irq_n};
			4'h9: cnd = {1'b1, |r_reg.acc};
			4'hB: cnd = {1'b1, r_reg.f0};
			4'hC: cnd = {1'b1, ~|r_reg.acc};
			4'hE: cnd = {1'b1, ~r_reg.cy};
			4'hF: cnd = {1'b1, r_reg.cy};
			default: cnd = 2'b00;
		endcase
		// interrupts enter only when enabled and idle
		take_ext = r_reg.irq_en & ~ext_irq_n & ~r_reg.insvc;
		take_tmr = r_reg.tirq_en & r_reg.tpend & ~r_reg.insvc;
		// prescaler or falling edge on test input b
		r_next.t1_prev = test_input_b;
		tick = 1'b0;
		if (r_reg.tmode == mcd_pkg::TM_TIMER) begin
			r_next.presc = r_reg.presc + 5'h01;
			tick = (r_reg.presc == mcd_pkg::PRESCALE_LAST);
		end else if (r_reg.tmode == mcd_pkg::TM_COUNT) begin
			tick = r_reg.t1_prev & ~test_input_b;
		end
		if (tick) begin
			r_next.timer = r_reg.timer + 8'h01;
		end
		case (r_reg.state)
			mcd_pkg::ST_FETCH: begin
				r_next.pc = pc1;
				r_next.addr = pc1;
				r_next.op = fetch_byte;
				r_next.imm = 1'b1;
				if (take_ext || take_tmr) begin
					// Fetched byte is dropped; its address is the return point
					r_next.pc = r_reg.pc;
					r_next.state = mcd_pkg::ST_INTR;
					r_next.op = take_ext ? mcd_pkg::VEC_EXT : mcd_pkg::VEC_TIMER;
					ram_we = 1'b1;
					ram_wa = stk_a;
					ram_wd = r_reg.pc[7:0];
					if (!take_ext) begin
						r_next.tpend = 1'b0;
					end
				end else begin
					casez (fetch_byte)
						8'b01??1???, 8'b01??000?, 8'b1101_1???, 8'b1101_000?: begin
							r_next.acc = alu_r[7:0];
							if (fetch_byte[7:5] == 3'b011) begin
								r_next.cy = alu_r[9];
								r_next.ac = alu_r[8];
							end
						end
						8'h17: r_next.acc = r_reg.acc + 8'h01;
						8'h07: r_next.acc = r_reg.acc - 8'h01;
						8'h27: r_next.acc = 8'h00;
						8'h37: r_next.acc = ~r_reg.acc;
						8'h57: begin
							r_next.acc = da_hi[7:0];
							r_next.cy = da_hi[8] | r_reg.cy;
						end
						8'h47: r_next.acc = {r_reg.acc[3:0], r_reg.acc[7:4]};
						8'hE7: r_next.acc = {r_reg.acc[6:0], r_reg.acc[7]};
						8'hF7: {r_next.cy, r_next.acc} = {r_reg.acc, r_reg.cy};
						8'h77: r_next.acc = {r_reg.acc[0], r_reg.acc[7:1]};
						8'h67: {r_next.acc, r_next.cy} = {r_reg.cy, r_reg.acc};
						8'b0001_1???, 8'b0001_000?: begin
							ram_we = 1'b1;
							ram_wd = mem_q + 8'h01;
						end
						8'b1100_1???: begin
							ram_we = 1'b1;
							ram_wd = mem_q - 8'h01;
						end
						8'b0010_1???, 8'b0010_000?: begin
							ram_we = 1'b1;
							r_next.acc = mem_q;
						end
						8'b0011_000?: begin
							ram_we = 1'b1;
							ram_wd = {mem_q[7:4], r_reg.acc[3:0]};
							r_next.acc = {r_reg.acc[7:4], mem_q[3:0]};
						end
						// Plain moves between accumulator and RAM
						8'b1111_1???, 8'b1111_000?: r_next.acc = mem_q;
						8'b1010_1???, 8'b1010_000?: ram_we = 1'b1;
						8'h42: r_next.acc = r_reg.timer;
						8'h62: r_next.timer = r_reg.acc;
						8'h55: begin
							r_next.tmode = mcd_pkg::TM_TIMER;
							r_next.presc = 5'h00;
						end
						8'h45: r_next.tmode = mcd_pkg::TM_COUNT;
						8'h65: r_next.tmode = mcd_pkg::TM_STOP;
						8'h25: r_next.tirq_en = 1'b1;
						8'h35: r_next.tirq_en = 1'b0;
						8'h05: r_next.irq_en = 1'b1;
						8'h15: r_next.irq_en = 1'b0;
						// Flags and memory bank
						8'h85: r_next.f0 = 1'b0;
						8'h95: r_next.f0 = ~r_reg.f0;
						8'hA5: r_next.f1 = 1'b0;
						8'hB5: r_next.f1 = ~r_reg.f1;
						8'hE5: r_next.mbf = 1'b0;
						8'hF5: r_next.mbf = 1'b1;
						// low return byte goes to the stack now
						8'b???1_0100: begin
							r_next.state = mcd_pkg::ST_EXEC2;
							ram_we = 1'b1;
							ram_wa = stk_a;
							ram_wd = pc1[7:0] + 8'h01;
						end
						// Two cycle forms that read a second program byte
						8'h03, 8'h13, 8'h53, 8'h43, 8'hD3, 8'h23, 8'h98, 8'h99, 8'h9A, 8'h88,
						8'h89, 8'h8A, 8'b???0_0100, 8'b???1_0010, 8'b1110_1???, 8'b1011_1???,
						8'b1011_000?:
							r_next.state = mcd_pkg::ST_EXEC2;
						8'b????0110: begin
							if (cnd[1]) begin
								r_next.state = mcd_pkg::ST_EXEC2;
							end
						end
						// Two cycle forms without an immediate byte: I/O, data, tables, indirect jump, returns
						8'h08, 8'h09, 8'h0A, 8'h39, 8'h3A, 8'h02, 8'b0000_11??, 8'b0011_11??,
						8'b1001_11??, 8'b1000_11??, 8'b1000_000?, 8'b1001_000?, 8'hA3,
						8'hE3, 8'hB3, 8'h83, 8'h93: begin
							r_next.state = mcd_pkg::ST_EXEC2;
							r_next.imm = 1'b0;
							r_next.xaddr = ptr;
							if (fetch_byte == 8'h08 || fetch_byte[7:1] == 7'h40) begin
								r_next.rd_n = 1'b0;
								r_next.bus_oe_n = 1'b1;
							end
							if (fetch_byte == 8'h02 || fetch_byte[7:1] == 7'h48) begin
								r_next.wr_n = 1'b0;
								r_next.bus_oe_n = 1'b0;
								r_next.bus = r_reg.acc;
							end
							if (fetch_byte[3:2] == 2'b11) begin
								r_next.exp = '{strobe: 1'b1, port: fetch_byte[1:0],
									op: {fetch_byte[7], fetch_byte[4] | (fetch_byte[5] & ~fetch_byte[7])},
									data: r_reg.acc[3:0]};
							end
							if (fetch_byte == 8'hA3 || fetch_byte == 8'hB3) begin
								r_next.addr = {pc1[11:8], r_reg.acc};
							end
							if (fetch_byte == 8'hE3) begin
								r_next.addr = {pc1[11], 3'b011, r_reg.acc};
							end
							if (fetch_byte[6:0] == 7'h03) begin
								r_next.sp = r_reg.sp - 3'h1;
							end
						end
						default: ;
					endcase
				end
			end
			mcd_pkg::ST_EXEC2: begin
				r_next.state = mcd_pkg::ST_FETCH;
				r_next.pc = r_reg.pc + {11'h000, r_reg.imm};
				r_next.rd_n = 1'b1;
				r_next.wr_n = 1'b1;
				r_next.exp.strobe = 1'b0;
				casez (r_reg.op)
					8'h03, 8'h13, 8'h53, 8'h43, 8'hD3: begin
						r_next.acc = alu_r[7:0];
						// Only the add forms (03, 13) update the carries
						if (r_reg.op[7:5] == 3'b000) begin
							r_next.cy = alu_r[9];
							r_next.ac = alu_r[8];
						end
					end
					8'h23: r_next.acc = fetch_byte;
					8'b1011_1???, 8'b1011_000?: begin
						ram_we = 1'b1;
						ram_wd = fetch_byte;
					end
					8'h09, 8'h0A: r_next.acc = r_reg.op[1] ? port2_in : port1_in;
					8'h39: r_next.p1 = r_reg.acc;
					8'h3A: r_next.p2 = r_reg.acc;
					8'h99: r_next.p1 = r_reg.p1 & fetch_byte;
					8'h9A: r_next.p2 = r_reg.p2 & fetch_byte;
					8'h89: r_next.p1 = r_reg.p1 | fetch_byte;
					8'h8A: r_next.p2 = r_reg.p2 | fetch_byte;
					// bus sampled as the read strobe ends
					8'h08, 8'b1000_000?: r_next.acc = bus_in;
					8'h98: r_next.bus = r_reg.bus & fetch_byte;
					8'h88: r_next.bus = r_reg.bus | fetch_byte;
					// expander read clears the upper nibble
					8'b0000_11??: r_next.acc = {4'h0, exp_in};
					8'b???0_0100: r_next.pc = {r_reg.mbf, r_reg.op[7:5], fetch_byte};
					// upper return byte with status, then jump
					8'b???1_0100: begin
						ram_we = 1'b1;
						ram_wa = stk_a + 6'h01;
						ram_wd = {r_reg.cy, r_reg.ac, r_reg.f0, 1'b0, pc1[11:8]};
						r_next.sp = r_reg.sp + 3'h1;
						r_next.pc = {r_reg.mbf, r_reg.op[7:5], fetch_byte};
					end
					// Accumulator bit test
					8'b???1_0010: begin
						if (r_reg.acc[r_reg.op[7:5]]) begin
							r_next.pc = {r_reg.pc[11:8], fetch_byte};
						end
					end
					8'b1110_1???: begin
						ram_we = 1'b1;
						ram_wd = mem_q - 8'h01;
						if (mem_q != 8'h01) begin
							r_next.pc = {r_reg.pc[11:8], fetch_byte};
						end
					end
					// the test of the timer flag clears it
					8'b????0110: begin
						if (cnd[0]) begin
							r_next.pc = {r_reg.pc[11:8], fetch_byte};
						end
						if (r_reg.op == 8'h16) begin
							r_next.tf = 1'b0;
						end
					end
					8'hB3: r_next.pc = {r_reg.pc[11:8], fetch_byte};
					8'hA3, 8'hE3: r_next.acc = fetch_byte;
					// Returns; the status form also ends interrupt service
					8'h83, 8'h93: begin
						r_next.pc = {ram[stk_a + 6'h01][3:0], ram[stk_a]};
						if (r_reg.op[4]) begin
							{r_next.cy, r_next.ac, r_next.f0} = ram[stk_a + 6'h01][7:5];
							r_next.insvc = 1'b0;
						end
					end
					default: ;
				endcase
				r_next.addr = r_next.pc;
			end
			mcd_pkg::ST_INTR: begin
				// Interrupt entry finishes like a call to the vector
				r_next.state = mcd_pkg::ST_FETCH;
				ram_we = 1'b1;
				ram_wa = stk_a + 6'h01;
				ram_wd = {r_reg.cy, r_reg.ac, r_reg.f0, 1'b0, r_reg.pc[11:8]};
				r_next.sp = r_reg.sp + 3'h1;
				r_next.pc = {4'h0, r_reg.op};
				r_next.addr = {4'h0, r_reg.op};
				r_next.insvc = 1'b1;
			end
			default: r_next.state = mcd_pkg::ST_FETCH;
		endcase
		// overflow placed last so it wins over the flag's clear
		if (tick && r_reg.timer == 8'hFF) begin
			r_next.tf = 1'b1;
			r_next.tpend = 1'b1;
		end
		// fetches above the internal store also go outside
		r_next.pext = external_fetch_select | (|r_next.addr[11:ROM_AW]);
	end

	// State register; strap of the fetch select is caught during reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r_reg <= mcd_pkg::REGS_RESET;
			r_reg.pext <= external_fetch_select;
		end else begin
			r_reg <= r_next;
		end
	end

	// Memories have no reset; software must not rely on their contents
	always_ff @(posedge clk_sys) begin
		if (ram_we && !sys_rst) begin
			ram[ram_wa] <= ram_wd;
		end
		if (prog_load_en) begin
			rom[prog_load_addr] <= prog_load_data;
		end
	end

	// Outputs straight from the state register
	assign prog_addr   = r_reg.addr;
	assign prog_ext_en = r_reg.pext;
	assign port1_out   = r_reg.p1;
	assign port2_out   = r_reg.p2;
	assign bus_out     = r_reg.bus;
	assign bus_oe_n    = r_reg.bus_oe_n;
	assign bus_rd_n    = r_reg.rd_n;
	assign bus_wr_n    = r_reg.wr_n;
	assign xdata_addr  = r_reg.xaddr;
	assign exp_out     = r_reg.exp;
	assign acc_out     = r_reg.acc;
	assign status_word = {r_reg.cy, r_reg.ac, r_reg.f0, 1'b0, 1'b1, r_reg.sp};

endmodule

`default_nettype wire

// ---- tb/mcd_core_chk.sv ----
// Checker for the decoder core, watching its ports only.
// Assumes the single clock and synchronous active-high reset of the core.
`timescale 1ns/10ps
`default_nettype none
module mcd_core_chk (
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	// Program fetch
	input wire logic              external_fetch_select,
	input wire logic              prog_ext_en,
	input wire logic [11:0]       prog_addr,
	// Bus and external data
	input wire logic [7:0]        bus_out,
	input wire logic              bus_oe_n,
	input wire logic              bus_rd_n,
	input wire logic              bus_wr_n,
	input wire logic [7:0]        xdata_addr,
	// Expander and visible state
	input wire mcd_pkg::mcd_exp_t exp_out,
	input wire logic [7:0]        port1_out,
	input wire logic [7:0]        status_word
);
	// All checks share the core clock; reset masks them
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	fetch_ext_a: assert property (external_fetch_select |=> prog_ext_en)
		else $error("external fetch select ignored");
	rd_pulse_a: assert property (!bus_rd_n |=> bus_rd_n)
		else $error("read strobe longer than one cycle");
	rd_float_a: assert property (!bus_rd_n |-> bus_oe_n)
		else $error("bus driven during read strobe");
	wr_drive_a: assert property (!bus_wr_n |-> !bus_oe_n ##1 (bus_wr_n && !bus_oe_n && $stable(bus_out)))
		else $error("bus write strobe or data wrong");
	strobe_excl_a: assert property (!(!bus_rd_n && !bus_wr_n))
		else $error("read and write strobes together");
	xaddr_hold_a: assert property (!bus_rd_n |=> $stable(xdata_addr))
		else $error("data address moved after read");
	exp_pulse_a: assert property (exp_out.strobe |=> !exp_out.strobe)
		else $error("expander strobe longer than one cycle");
	reset_state_a: assert property ($fell(sys_rst) |-> prog_addr == 12'h000 && port1_out == 8'hFF
		&& status_word == 8'h08)
		else $error("state after reset wrong");

	// Main traffic kinds seen at least once
	cov_rd: cover property (!bus_rd_n);
	cov_wr: cover property (!bus_wr_n);
	cov_exp: cover property (exp_out.strobe);
endmodule
bind mcd_core mcd_core_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.external_fetch_select(external_fetch_select), .prog_ext_en(prog_ext_en),
	.prog_addr(prog_addr), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .bus_rd_n(bus_rd_n),
	.bus_wr_n(bus_wr_n), .xdata_addr(xdata_addr), .exp_out(exp_out), .port1_out(port1_out),
	.status_word(status_word));
`default_nettype wire

// ---- tb/mcd_ext_mem.sv ----
// Model of external program memory, data memory and expander.
// Assumes the bench loads rom directly; released lines toggle each cycle.
`timescale 1ns/10ps
`default_nettype none
module mcd_ext_mem (
	// Clock
	input  wire logic              clk_sys,
	// Program side
	input  wire logic [11:0]       prog_addr,
	input  wire logic              prog_ext_en,
	output logic [7:0]             prog_data_in,
	// Bus side
	input  wire logic [7:0]        bus_out,
	input  wire logic              bus_rd_n,
	input  wire logic              bus_wr_n,
	input  wire logic [7:0]        xdata_addr,
	output logic [7:0]             bus_in,
	// Expander side
	input  wire mcd_pkg::mcd_exp_t exp_out,
	output logic [3:0]             exp_in
);
	logic [7:0] rom [0:255];  // Program bytes, small programs only
	logic [7:0] ram [0:255];  // External data bytes
	logic [3:0] nib [0:3];    // Expander port latches
	logic       tog = 1'b0;   // Pattern for released lines, so no stale value reads true

	assign prog_data_in = prog_ext_en ? rom[prog_addr[7:0]] : {8{tog}};
	assign bus_in = !bus_rd_n ? ram[xdata_addr] : {8{tog}};
	assign exp_in = (exp_out.strobe && exp_out.op == 2'h0) ? nib[exp_out.port] : {4{tog}};

	// Data and expander writes taken on the strobe cycle
	always @(posedge clk_sys) begin
		tog <= ~tog;
		if (!bus_wr_n) ram[xdata_addr] <= bus_out;
		if (exp_out.strobe && exp_out.op == 2'h1) nib[exp_out.port] <= exp_out.data;
		if (exp_out.strobe && exp_out.op == 2'h2) nib[exp_out.port] <= nib[exp_out.port] | exp_out.data;
		if (exp_out.strobe && exp_out.op == 2'h3) nib[exp_out.port] <= nib[exp_out.port] & exp_out.data;
	end
endmodule
`default_nettype wire

// ---- tb/test_mcd_core.sv ----
// Self-checking bench for the decoder core with an external memory model.
// Assumes a 20 MHz clock; programs run from small external or internal stores.
`timescale 1ns/10ps
`default_nettype none
module test_mcd_core;
	// One row: loaded value, opcode, second byte, expected accumulator and carry
	typedef struct packed {
		logic [7:0] pre;
		logic [7:0] op;
		logic [7:0] arg;
		logic [7:0] acc;
		logic       cy;
	} mcd_row_t;

	logic              clk_sys = 1'b0;     // 50 ns period
	logic              sys_rst = 1'b1;     // Held at start
	logic              external_fetch_select = 1'b1;
	logic              prog_load_en = 1'b0;
	logic [9:0]        prog_load_addr = 10'h000;
	logic [7:0]        prog_load_data = 8'h00;
	logic [7:0]        prog_data_in, bus_in, port1_out, port2_out, bus_out, xdata_addr;
	logic [7:0]        acc_out, status_word;
	logic [3:0]        exp_in;
	logic [11:0]       prog_addr;
	logic              prog_ext_en, bus_oe_n, bus_rd_n, bus_wr_n;
	mcd_pkg::mcd_exp_t exp_out;
	int                failures = 0;       // Mismatches seen
	int                checks_done = 0;    // Comparisons made
	int                cycles = 0;         // Hang guard
	mcd_row_t          rows [0:15] = '{
		'{8'h19, 8'h03, 8'h27, 8'h40, 1'b0}, '{8'hF0, 8'h03, 8'h20, 8'h10, 1'b1},
		'{8'h88, 8'h13, 8'h88, 8'h10, 1'b1}, '{8'hF0, 8'h53, 8'h3C, 8'h30, 1'b0},
		'{8'hF0, 8'h43, 8'h3C, 8'hFC, 1'b0}, '{8'hF0, 8'hD3, 8'h3C, 8'hCC, 1'b0},
		'{8'hFF, 8'h17, 8'h00, 8'h00, 1'b0}, '{8'h00, 8'h07, 8'h00, 8'hFF, 1'b0},
		'{8'h5A, 8'h27, 8'h00, 8'h00, 1'b0}, '{8'h5A, 8'h37, 8'h00, 8'hA5, 1'b0},
		'{8'h9A, 8'h57, 8'h00, 8'h00, 1'b1}, '{8'h12, 8'h47, 8'h00, 8'h21, 1'b0},
		'{8'h81, 8'hE7, 8'h00, 8'h03, 1'b0}, '{8'h81, 8'hF7, 8'h00, 8'h02, 1'b1},
		'{8'h81, 8'h67, 8'h00, 8'h40, 1'b1}, '{8'h5A, 8'h66, 8'h00, 8'h5A, 1'b0}};

	// Clock
	always #25 clk_sys = ~clk_sys;

	mcd_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.external_fetch_select(external_fetch_select), .prog_load_en(prog_load_en),
		.prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
		.prog_data_in(prog_data_in), .prog_addr(prog_addr), .prog_ext_en(prog_ext_en),
		.port1_in(8'h77), .port2_in(8'h3C), .port1_out(port1_out), .port2_out(port2_out),
		.bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .bus_rd_n(bus_rd_n),
		.bus_wr_n(bus_wr_n), .xdata_addr(xdata_addr), .exp_in(exp_in), .exp_out(exp_out),
		.test_input_a(1'b0), .test_input_b(1'b1), .ext_irq_n(1'b1), .acc_out(acc_out),
		.status_word(status_word));

	mcd_ext_mem mem (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_ext_en(prog_ext_en),
		.prog_data_in(prog_data_in), .bus_out(bus_out), .bus_rd_n(bus_rd_n),
		.bus_wr_n(bus_wr_n), .xdata_addr(xdata_addr), .bus_in(bus_in), .exp_out(exp_out),
		.exp_in(exp_in));

	// Compare and count
	task automatic check_eq(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Load a program, reset briefly so it starts at zero, run n cycles
	task automatic run_prog(input logic [7:0] code [$], input logic sel, input int n);
		for (int i = 0; i < 256; i++) mem.rom[i] = (i < code.size()) ? code[i] : 8'h00;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		external_fetch_select <= sel;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// Closing report
	task automatic give_verdict;
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs well under 2000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		// Internal store loaded during the opening reset
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			prog_load_en <= 1'b1;
			prog_load_addr <= 10'(i);
			prog_load_data <= (i == 1) ? 8'h5A : ((i == 0) ? 8'h23 : ((i == 2) ? 8'h04 : 8'h02));
		end
		@(posedge clk_sys);
		prog_load_en <= 1'b0;
		repeat (11) @(posedge clk_sys);
		@(negedge clk_sys);
		check_eq(port1_out, 8'hFF);
		check_eq(status_word, 8'h08);
		check_eq(acc_out, 8'h00);
		check_eq(prog_addr, 12'h000);
		// Arithmetic, logic and undefined opcodes
		foreach (rows[k]) begin
			run_prog({8'h23, rows[k].pre, rows[k].op, rows[k].arg, 8'h04, 8'h04}, 1'b1, 8);
			check_eq(acc_out, rows[k].acc);
			check_eq(status_word[7], rows[k].cy);
		end
		// Internal store versus forced external fetch
		run_prog({8'h23, 8'hA5, 8'h04, 8'h02}, 1'b0, 8);
		check_eq(acc_out, 8'h5A);
		check_eq(prog_ext_en, 1'b0);
		run_prog({8'h23, 8'hA5, 8'h04, 8'h02}, 1'b1, 8);
		check_eq(acc_out, 8'hA5);
		// External data and bus moves through R0; the closing read releases the bus
		run_prog({8'hB8, 8'h21, 8'h23, 8'h5A, 8'h90, 8'h27, 8'h08, 8'h23, 8'h66, 8'h02,
			8'h98, 8'h0F, 8'h27, 8'h80, 8'h04, 8'h0E}, 1'b1, 40);
		check_eq(acc_out, 8'h66);
		check_eq(bus_out, 8'h06);
		check_eq(bus_oe_n, 1'b1);
		// Ports: write, and, or, read
		run_prog({8'h23, 8'h3C, 8'h39, 8'h99, 8'h0F, 8'h9A, 8'h81, 8'h89, 8'h40, 8'h09,
			8'h04, 8'h0A}, 1'b1, 40);
		check_eq(port1_out, 8'h4C);
		check_eq(port2_out, 8'h81);
		check_eq(acc_out, 8'h77);
		// Expander: write, and, or, read back
		run_prog({8'h23, 8'hA6, 8'h3D, 8'h23, 8'hF5, 8'h9D, 8'h23, 8'h01, 8'h8D, 8'h0D,
			8'h04, 8'h0A}, 1'b1, 40);
		check_eq(acc_out, 8'h05);
		// Loop count, carry and accumulator branches, jump
		run_prog({8'hB8, 8'h03, 8'h17, 8'hE8, 8'h02, 8'hF6, 8'h0B, 8'h96, 8'h0C, 8'h27,
			8'h00, 8'h27, 8'h37, 8'h04, 8'h0D}, 1'b1, 40);
		check_eq(acc_out, 8'hFC);
		// Memory increment, exchanges, call and table read chained through the accumulator
		run_prog({8'hB9, 8'h30, 8'h23, 8'h12, 8'hA1, 8'h11, 8'h23, 8'hF4, 8'h31, 8'h21,
			8'h14, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA3, 8'h04, 8'h11, 8'h00,
			8'h9C}, 1'b1, 40);
		check_eq(acc_out, 8'h9C);
		check_eq(status_word[2:0], 3'h1);
		// Timer loaded near overflow, run, flag branch taken, timer read back
		run_prog({8'h23, 8'hFE, 8'h62, 8'h55, 8'h16, 8'h08, 8'h04, 8'h04, 8'h42, 8'h04,
			8'h09}, 1'b1, 100);
		check_eq(acc_out, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
